// File: shared/ecmr_pkg.sv
package ecmr_pkg;

    // Data and address width of the internal register interface
    localparam int DW = 32;

    // Register offsets relative to the bank base
    localparam logic [31:0] OFS_SRAM_CFG = 32'h0000_0000;
    localparam logic [31:0] OFS_ERR_ADDR = 32'h0000_0004;
    localparam logic [31:0] OFS_WDT_CNT = 32'h0000_0028;
    localparam logic [31:0] OFS_IO_PWR = 32'h0000_0064;
    localparam logic [31:0] OFS_SCAN_STAT = 32'h0000_0074;

    // Field positions and reset values
    localparam int SRAM_SIZE_W = 2;
    localparam logic [31:0] IO_PWR_MASK = 32'h0000_00FF;
    localparam logic [31:0] IO_PWR_RST = 32'h0000_0000;
    localparam logic [31:0] ERR_ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] WDT_CNT_RST = 32'h0000_0000;
    localparam logic [1:0] SRAM_SIZE_RST = 2'h0;

    // Plain read/write control registers, one table entry each
    localparam int NSIMP = 11;
    localparam int IDX_ERR_CTRL = 0;
    localparam int IDX_IRQ_ROUTE = 1;
    localparam int IDX_TRACE_EN = 2;
    localparam int IDX_DEBUG_EN = 3;
    localparam int IDX_OTP_LOCK = 4;
    localparam int IDX_THERM_DIS = 5;
    localparam int IDX_SCAN_CFG = 6;
    localparam int IDX_SCAN_OUT = 7;
    localparam int IDX_SCAN_IN = 8;
    localparam int IDX_SCAN_MODE = 9;
    localparam int IDX_SCAN_CMD = 10;
    localparam logic [31:0] SIMP_OFS [NSIMP] = '{
        32'h14, 32'h18, 32'h1C, 32'h20, 32'h24, 32'h40,
        32'h70, 32'h78, 32'h7C, 32'h80, 32'h84};
    localparam logic [31:0] SIMP_MASK [NSIMP] = '{
        32'h3, 32'h1, 32'h1, 32'hF, 32'hFF, 32'h1,
        32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
    localparam logic [31:0] SIMP_RST [NSIMP] = '{
        32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

    // Memory map per size code
    localparam logic [1:0] SRAM_480 = 2'h3;
    localparam logic [1:0] SRAM_320 = 2'h2;
    localparam logic [1:0] SRAM_256 = 2'h1;
    localparam logic [9:0] KB_480 = 10'h1E0;
    localparam logic [9:0] KB_320 = 10'h140;
    localparam logic [9:0] KB_256 = 10'h100;
    localparam logic [31:0] CODE_START_480 = 32'h000B_0000;
    localparam logic [31:0] CODE_START_320 = 32'h000D_0000;
    localparam logic [31:0] CODE_START_256 = 32'h000E_0000;
    localparam logic [31:0] CODE_END = 32'h0011_7FFF;
    localparam logic [31:0] DATA_START = 32'h0011_8000;
    localparam logic [31:0] DATA_END_480 = 32'h0012_7FFF;
    localparam logic [31:0] DATA_END_SMALL = 32'h0001_1FFF;

    // Register request carried from the processor side
    typedef struct packed {
        logic wr;
        logic rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ecmr_req_t;

    // Power state of the bank
    typedef enum logic {
        ECMR_AWAKE = 1'b0,
        ECMR_ASLEEP = 1'b1
    } ecmr_pwr_t;

endpackage

// File: hw/ecmr_err_cap.sv
module ecmr_err_cap (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_err,
    input wire logic [31:0] i_err_addr,
    input wire logic i_clr,
    output logic [31:0] o_addr_q
);
    import ecmr_pkg::*;

    // First faulting address; capture beats the clearing write
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_addr_q <= ERR_ADDR_RST;
        end else if (i_err && o_addr_q == ERR_ADDR_RST) begin
            o_addr_q <= i_err_addr;
        end else if (i_clr) begin
            o_addr_q <= ERR_ADDR_RST;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    AST_ERR_FIRST: assert property (
        i_err && o_addr_q == 32'h0 |=> o_addr_q == $past(i_err_addr))
        else $error("fault address not captured");
    AST_ERR_KEEP: assert property (
        o_addr_q != 32'h0 && !i_clr |=> o_addr_q == $past(o_addr_q))
        else $error("held fault address overwritten");
    AST_ERR_CLR: assert property (
        i_clr && !(i_err && o_addr_q == 32'h0) |=> o_addr_q == 32'h0)
        else $error("write did not clear fault address");
    AST_ERR_PRIO: assert property (
        i_clr && i_err && o_addr_q == 32'h0 |=> o_addr_q == $past(i_err_addr))
        else $error("clear won over capture");
    COV_ERR_COLLIDE: cover property (i_clr && i_err && o_addr_q == 32'h0);

endmodule

// File: hw/ecmr_sram_map.sv
module ecmr_sram_map (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [1:0] i_code,
    output logic [9:0] o_total_kb,
    output logic [31:0] o_code_start,
    output logic [31:0] o_data_end
);
    import ecmr_pkg::*;

    // Decode the size code into the memory map; code 0 shows all zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_total_kb <= 10'h000;
            o_code_start <= 32'h0000_0000;
            o_data_end <= 32'h0000_0000;
        end else begin
            unique case (i_code)
                SRAM_480: begin
                    o_total_kb <= KB_480;
                    o_code_start <= CODE_START_480;
                    o_data_end <= DATA_END_480;
                end
                SRAM_320: begin
                    o_total_kb <= KB_320;
                    o_code_start <= CODE_START_320;
                    o_data_end <= DATA_END_SMALL;
                end
                SRAM_256: begin
                    o_total_kb <= KB_256;
                    o_code_start <= CODE_START_256;
                    o_data_end <= DATA_END_SMALL;
                end
                2'h0: begin
                    o_total_kb <= 10'h000; // Reserved code
                    o_code_start <= 32'h0000_0000;
                    o_data_end <= 32'h0000_0000;
                end
            endcase
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    AST_MAP_480: assert property (
        i_code == 2'h3 |=> o_total_kb == 10'h1E0 && o_code_start == 32'hB_0000)
        else $error("wrong map for code 3");
    AST_MAP_256: assert property (
        i_code == 2'h1 |=> o_total_kb == 10'h100 && o_code_start == 32'hE_0000)
        else $error("wrong map for code 1");

endmodule

// File: hw/ecmr_bank.sv
// Functional notes
// - All accesses run on the host clock
// - System reset clears all but watchdog count
// - Watchdog count has own reset, not watchdog
// - Standby reset only at standby power-up
// - No interrupt outputs at all
// - Accesses still work while asleep
// - Register address is base plus offset
// - Size code 3 means 480KB map
// - Size code 2 means 320KB map
// - Size code 1 means 256KB map
// - Keep only first bus fault address
// - Any write to it clears fault address
// - Fault capture beats clearing write
module ecmr_bank (
    input wire logic I_SYS_CLK,
    input wire logic I_RST_N,
    input wire logic I_WDT_CNT_RST_N,
    input wire logic I_STBY_RST_N,
    input wire logic [31:0] I_BASE_ADDR,
    input wire ecmr_pkg::ecmr_req_t I_REQ,
    input wire logic [1:0] I_SRAM_SIZE_STRAP,
    input wire logic I_BUS_ERR,
    input wire logic [31:0] I_BUS_ERR_ADDR,
    input wire logic I_WDT_EVENT,
    input wire logic [31:0] I_SCAN_STATUS,
    input wire logic I_SLEEP_REQ,
    output logic [31:0] O_REG_RDATA,
    output logic O_REG_ACK,
    output logic [ecmr_pkg::NSIMP-1:0][31:0] O_CTRL_REGS,
    output logic [31:0] O_IO_BANK_PWR,
    output logic [31:0] O_WDT_COUNT,
    output logic [9:0] O_SRAM_TOTAL_KB,
    output logic [31:0] O_SRAM_CODE_START,
    output logic [31:0] O_SRAM_DATA_END,
    output logic O_SLEEP_ACK
);
    import ecmr_pkg::*;

    // This bank raises no events toward any interrupt controller, so
    // the port list carries no interrupt output.

    // Offset of the current access within the bank
    logic [31:0] ofs;
    // Qualified write and read strobes
    logic wr_en;
    logic rd_en;
    // Write hit on the fault address register
    logic err_clr;
    // Combinational read data
    logic [31:0] rdata_d;
    // Captured size code and its one-shot capture flag
    logic [1:0] sram_code_q;
    logic strap_taken_q;
    // Power state
    ecmr_pwr_t pwr_q;
    ecmr_pwr_t pwr_d;
    // Fault address from the capture unit
    logic [31:0] err_addr;
    // Combined reset of the bank power register
    logic io_rst_n;

    // Offset is the bus address minus the bank base
    assign ofs = I_REQ.addr - I_BASE_ADDR;
    // Sleep does not gate the strobes
    assign wr_en = I_REQ.wr;
    assign rd_en = I_REQ.rd;
    assign err_clr = wr_en && ofs == OFS_ERR_ADDR;

    // Plain control registers, one flop set per table entry
    genvar g;
    generate
        for (g = 0; g < NSIMP; g++) begin : g_simp
            // Store masked write data; reserved bits stay zero
            always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
                if (!I_RST_N) begin
                    O_CTRL_REGS[g] <= SIMP_RST[g];
                end else if (wr_en && ofs == SIMP_OFS[g]) begin
                    O_CTRL_REGS[g] <= I_REQ.wdata & SIMP_MASK[g];
                end
            end
            // A hit stores the masked word, a miss leaves the entry alone
            AST_CTRL_WR: assert property (
                @(posedge I_SYS_CLK) disable iff (!I_RST_N)
                wr_en && ofs == SIMP_OFS[g]
                |=> O_CTRL_REGS[g] == ($past(I_REQ.wdata) & SIMP_MASK[g]))
                else $error("table write not stored");
            AST_CTRL_KEEP: assert property (
                @(posedge I_SYS_CLK) disable iff (!I_RST_N)
                !(wr_en && ofs == SIMP_OFS[g]) |=> $stable(O_CTRL_REGS[g]))
                else $error("table entry changed without a write");
        end
    endgenerate

    // Either reset clears the bank power register; the system reset
    // spares nothing but the watchdog count
    assign io_rst_n = I_RST_N & I_STBY_RST_N;

    // IO bank power, cleared by the standby or the system reset
    always_ff @(posedge I_SYS_CLK or negedge io_rst_n) begin
        if (!io_rst_n) begin
            O_IO_BANK_PWR <= IO_PWR_RST;
        end else if (wr_en && ofs == OFS_IO_PWR) begin
            O_IO_BANK_PWR <= I_REQ.wdata & IO_PWR_MASK;
        end
    end

    // Watchdog event count survives system and watchdog resets
    always_ff @(posedge I_SYS_CLK or negedge I_WDT_CNT_RST_N) begin
        if (!I_WDT_CNT_RST_N) begin
            O_WDT_COUNT <= WDT_CNT_RST;
        end else if (wr_en && ofs == OFS_WDT_CNT) begin
            // Software load takes precedence over an event
            O_WDT_COUNT <= I_REQ.wdata;
        end else if (I_WDT_EVENT) begin
            // Count each watchdog event, wrapping at the top
            O_WDT_COUNT <= O_WDT_COUNT + 32'h0000_0001;
        end
    end

    // Size strap is caught once, after the system reset releases
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            sram_code_q <= SRAM_SIZE_RST;
            strap_taken_q <= 1'b0;
        end else if (!strap_taken_q) begin
            sram_code_q <= I_SRAM_SIZE_STRAP;
            strap_taken_q <= 1'b1;
        end
    end

    // First fault capture and write-to-clear
    ecmr_err_cap u_err_cap (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_err(I_BUS_ERR),
        .i_err_addr(I_BUS_ERR_ADDR),
        .i_clr(err_clr),
        .o_addr_q(err_addr)
    );

    // Memory map decode of the captured size code
    ecmr_sram_map u_sram_map (
        .i_clk(I_SYS_CLK),
        .i_rst_n(I_RST_N),
        .i_code(sram_code_q),
        .o_total_kb(O_SRAM_TOTAL_KB),
        .o_code_start(O_SRAM_CODE_START),
        .o_data_end(O_SRAM_DATA_END)
    );

    // Read multiplexer; unmapped and reserved locations give zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (ofs == OFS_SRAM_CFG) begin
            // Size code in the low bits, rest reserved
            rdata_d = {30'h0000_0000, sram_code_q};
        end else if (ofs == OFS_ERR_ADDR) begin
            rdata_d = err_addr;
        end else if (ofs == OFS_WDT_CNT) begin
            rdata_d = O_WDT_COUNT;
        end else if (ofs == OFS_IO_PWR) begin
            rdata_d = O_IO_BANK_PWR;
        end else if (ofs == OFS_SCAN_STAT) begin
            rdata_d = I_SCAN_STATUS;
        end else begin
            // Search the control table
            for (int i = 0; i < NSIMP; i++) begin
                if (ofs == SIMP_OFS[i]) begin
                    rdata_d = O_CTRL_REGS[i];
                end
            end
        end
    end

    // Registered read data, refreshed only on reads
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_REG_RDATA <= 32'h0000_0000;
        end else if (rd_en) begin
            O_REG_RDATA <= rdata_d;
        end
    end

    // Every access is answered one clock later, awake or asleep
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_REG_ACK <= 1'b0;
        end else begin
            O_REG_ACK <= rd_en | wr_en;
        end
    end

    // Sleep handshake state
    always_comb begin
        pwr_d = pwr_q;
        unique case (pwr_q)
            ECMR_AWAKE: begin
                // Enter sleep on command
                if (I_SLEEP_REQ) begin
                    pwr_d = ECMR_ASLEEP;
                end
            end
            ECMR_ASLEEP: begin
                // Wake when the command drops
                if (!I_SLEEP_REQ) begin
                    pwr_d = ECMR_AWAKE;
                end
            end
        endcase
    end

    // Sleep state register
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pwr_q <= ECMR_AWAKE;
        end else begin
            pwr_q <= pwr_d;
        end
    end

    // Acknowledge flag toward the power controller
    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_SLEEP_ACK <= 1'b0;
        end else begin
            O_SLEEP_ACK <= (pwr_d == ECMR_ASLEEP);
        end
    end

    // Checks on the register interface
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);

    AST_ACK_NEXT: assert property (
        (I_REQ.rd || I_REQ.wr) |=> O_REG_ACK ##1 (O_REG_ACK == $past(I_REQ.rd || I_REQ.wr)))
        else $error("access not answered in one cycle");
    AST_IDLE_NO_ACK: assert property (
        !(I_REQ.rd || I_REQ.wr) |=> !O_REG_ACK)
        else $error("answer without access");
    AST_SLEEP_RW: assert property (
        O_SLEEP_ACK && I_REQ.rd && I_REQ.addr == I_BASE_ADDR + OFS_WDT_CNT
        && !I_REQ.wr |=> O_REG_RDATA == $past(O_WDT_COUNT))
        else $error("read failed while asleep");
    AST_RSVD_ZERO: assert property (
        (O_CTRL_REGS[IDX_ERR_CTRL] & ~SIMP_MASK[IDX_ERR_CTRL]) == 32'h0
        && (O_IO_BANK_PWR & ~IO_PWR_MASK) == 32'h0)
        else $error("reserved bit set");
    AST_SRAM_RO: assert property (
        strap_taken_q |=> $stable(sram_code_q))
        else $error("size code changed after capture");
    AST_SRAM_READ: assert property (
        I_REQ.rd && ofs == OFS_SRAM_CFG |=> O_REG_RDATA[31:2] == 30'h0
        && O_REG_RDATA[1:0] == $past(sram_code_q))
        else $error("size register read wrong");
    AST_WDT_INC: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_WDT_CNT_RST_N)
        I_WDT_EVENT && !(I_REQ.wr && ofs == OFS_WDT_CNT)
        |=> O_WDT_COUNT == $past(O_WDT_COUNT) + 32'h1)
        else $error("watchdog event not counted");
    AST_IRQ_ROUTE_RST: assert property (
        $rose(I_RST_N) |-> O_CTRL_REGS[IDX_IRQ_ROUTE] == 32'h1
        && O_CTRL_REGS[IDX_TRACE_EN] == 32'h0)
        else $error("control register reset value wrong");

    // Reset values seen at the first edge after the system reset
    AST_SYS_RST_VAL: assert property (
        $rose(I_RST_N) |-> O_IO_BANK_PWR == IO_PWR_RST && O_REG_RDATA == 32'h0
        && !O_REG_ACK && !O_SLEEP_ACK && err_addr == 32'h0 && O_SRAM_TOTAL_KB == 10'h0)
        else $error("system reset left a register set");

    // Read data moves only on a read
    AST_RDATA_HOLD: assert property (
        !I_REQ.rd |=> $stable(O_REG_RDATA))
        else $error("read data moved without a read");

    // Reads of the fault address and bank power registers
    AST_ERR_READ: assert property (
        I_REQ.rd && ofs == OFS_ERR_ADDR |=> O_REG_RDATA == $past(err_addr))
        else $error("fault address read wrong");
    AST_IO_READ: assert property (
        I_REQ.rd && I_REQ.addr == I_BASE_ADDR + OFS_IO_PWR
        |=> O_REG_RDATA == $past(O_IO_BANK_PWR))
        else $error("bank power read wrong");

    // Unmapped offsets read as zero
    AST_HOLE_ZERO: assert property (
        I_REQ.rd && (ofs == 32'h0000_0008 || ofs == 32'h0000_0100)
        |=> O_REG_RDATA == 32'h0)
        else $error("unmapped offset read nonzero");

    // Bank power write keeps the used bits only
    AST_IO_WR: assert property (
        @(posedge I_SYS_CLK) disable iff (!io_rst_n)
        wr_en && ofs == OFS_IO_PWR |=> O_IO_BANK_PWR == ($past(I_REQ.wdata) & IO_PWR_MASK))
        else $error("bank power write not stored");

    // Software load of the watchdog count, awake or asleep
    AST_WDT_LOAD: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_WDT_CNT_RST_N)
        wr_en && ofs == OFS_WDT_CNT |=> O_WDT_COUNT == $past(I_REQ.wdata))
        else $error("watchdog count load lost");
    AST_SLEEP_WR: assert property (
        @(posedge I_SYS_CLK) disable iff (!I_WDT_CNT_RST_N)
        O_SLEEP_ACK && wr_en && ofs == OFS_WDT_CNT |=> O_WDT_COUNT == $past(I_REQ.wdata))
        else $error("write lost while asleep");

    // Sleep acknowledge tracks the command one cycle later
    AST_SLEEP_ON: assert property (
        I_SLEEP_REQ |=> O_SLEEP_ACK)
        else $error("sleep not acknowledged");
    AST_SLEEP_OFF: assert property (
        !I_SLEEP_REQ |=> !O_SLEEP_ACK)
        else $error("sleep acknowledge stuck");
    AST_ACK_ASLEEP: assert property (
        O_SLEEP_ACK && (I_REQ.rd || I_REQ.wr) |=> O_REG_ACK)
        else $error("access refused while asleep");

    // Strap caught once after release; decode of code 2 and code 0
    AST_STRAP_TAKE: assert property (
        !strap_taken_q |=> sram_code_q == $past(I_SRAM_SIZE_STRAP))
        else $error("size strap not captured");
    AST_MAP_320: assert property (
        sram_code_q == SRAM_320 |=> O_SRAM_TOTAL_KB == KB_320
        && O_SRAM_CODE_START == CODE_START_320 && O_SRAM_DATA_END == DATA_END_SMALL)
        else $error("wrong map for code 2");
    AST_MAP_RSVD: assert property (
        sram_code_q == 2'h0 |=> O_SRAM_TOTAL_KB == 10'h000 && O_SRAM_CODE_START == 32'h0)
        else $error("reserved code not decoded to zero");

    COV_SLEEP_WRITE: cover property (O_SLEEP_ACK && I_REQ.wr);
    COV_WDT_EVENT: cover property (I_WDT_EVENT);
    COV_ERR_READ: cover property (I_REQ.rd && ofs == OFS_ERR_ADDR && err_addr != 32'h0);
    COV_UNMAPPED: cover property (I_REQ.rd && ofs == 32'h0000_0008);

endmodule

// File: dv/ecmr_cpu_model.sv
// Processor side of the register interface: one strobed access at a time
module ecmr_cpu_model
    import ecmr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_ack,
    input wire logic [31:0] i_rdata,
    output ecmr_pkg::ecmr_req_t o_req
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial o_req = '0;

    // Strobe for one cycle, then take the answer one cycle after the strobe
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rdv, output logic ak);
        @(negedge i_clk);
        o_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge i_clk);
        rdv = i_rdata;
        ak = i_ack;
        o_req.wr <= 1'b0;
        o_req.rd <= 1'b0;
        // Released address and data show the inverse, never the old value
        o_req.addr <= ~a;
        o_req.wdata <= ~d;
    endtask
endmodule

// File: dv/ec_misc_register_bank_tb.sv
// Compare one value pair and count it
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module ec_misc_register_bank_tb import ecmr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0, rst_n = 1'b0, wrst_n = 1'b0, srst_n = 1'b0;
    logic [31:0] base = 32'h0, scan = 32'h0, eaddr = 32'h0;
    logic [1:0] strap = SRAM_480;
    logic berr = 1'b0, wev = 1'b0, slp = 1'b0;
    ecmr_req_t req;
    logic [31:0] rdata, io_pwr, wcnt, cstart, dend;
    logic ack, sack;
    logic [NSIMP-1:0][31:0] ctrl;
    logic [9:0] tkb;
    int n_fail = 0, tests_run = 0, cyc = 0;
    // Behavioural model state
    logic [31:0] m_simp [NSIMP] = SIMP_RST;
    logic [31:0] m_err = 32'h0, m_wdt = 32'h0, m_io = 32'h0, rv, d;
    logic [1:0] m_code = SRAM_480;
    logic ak;
    int extra [$] = '{0, 4, 'h8, 'h28, 'h64, 'h74, 'h100};

    // 40 MHz host clock
    always #12.5 clk = ~clk;

    ecmr_bank dut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_WDT_CNT_RST_N(wrst_n),
        .I_STBY_RST_N(srst_n), .I_BASE_ADDR(base), .I_REQ(req), .I_SRAM_SIZE_STRAP(strap),
        .I_BUS_ERR(berr), .I_BUS_ERR_ADDR(eaddr), .I_WDT_EVENT(wev), .I_SCAN_STATUS(scan),
        .I_SLEEP_REQ(slp), .O_REG_RDATA(rdata), .O_REG_ACK(ack), .O_CTRL_REGS(ctrl),
        .O_IO_BANK_PWR(io_pwr), .O_WDT_COUNT(wcnt), .O_SRAM_TOTAL_KB(tkb),
        .O_SRAM_CODE_START(cstart), .O_SRAM_DATA_END(dend), .O_SLEEP_ACK(sack));

    ecmr_cpu_model cpu (.i_clk(clk), .i_ack(ack), .i_rdata(rdata), .o_req(req));

    // Verdict and end of run
    task final_report;
        if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report;
        end
    end

    // Model read value of one offset; unmapped places read zero
    function automatic logic [31:0] exp_rd(int o);
        exp_rd = 32'h0;
        for (int i = 0; i < NSIMP; i++) if (SIMP_OFS[i] == o) exp_rd = m_simp[i];
        if (o == OFS_SRAM_CFG) exp_rd = {30'h0, m_code};
        if (o == OFS_ERR_ADDR) exp_rd = m_err;
        if (o == OFS_WDT_CNT) exp_rd = m_wdt;
        if (o == OFS_IO_PWR) exp_rd = m_io;
        if (o == OFS_SCAN_STAT) exp_rd = scan;
    endfunction

    // Write through the processor model, then update the model
    task automatic wr(int o, logic [31:0] v);
        cpu.acc(1'b1, base + o, v, rv, ak);
        `CHK("wr ack", 1'b1, ak)
        for (int i = 0; i < NSIMP; i++) if (SIMP_OFS[i] == o) m_simp[i] = v & SIMP_MASK[i];
        if (o == OFS_ERR_ADDR) m_err = 32'h0;
        if (o == OFS_WDT_CNT) m_wdt = v;
        if (o == OFS_IO_PWR) m_io = v & IO_PWR_MASK;
    endtask

    // Read one offset and compare with the model
    task automatic rd_chk(int o);
        cpu.acc(1'b0, base + o, 32'h0, rv, ak);
        `CHK("rd ack", 1'b1, ak)
        `CHK("rdata", exp_rd(o), rv)
    endtask

    // Read every mapped register and a few unmapped places
    task automatic rd_all;
        for (int i = 0; i < NSIMP; i++) begin
            rd_chk(SIMP_OFS[i]);
            `CHK("ctrl reg", m_simp[i], ctrl[i])
        end
        foreach (extra[k]) rd_chk(extra[k]);
    endtask

    // Memory map outputs for the current size code
    task automatic chk_map;
        logic [9:0] k;
        logic [31:0] s, e;
        k = 10'h0;
        s = 32'h0;
        e = 32'h0;
        case (m_code)
            SRAM_480: begin k = KB_480; s = CODE_START_480; e = DATA_END_480; end
            SRAM_320: begin k = KB_320; s = CODE_START_320; e = DATA_END_SMALL; end
            SRAM_256: begin k = KB_256; s = CODE_START_256; e = DATA_END_SMALL; end
            default: ;
        endcase
        `CHK("total kb", k, tkb)
        `CHK("code start", s, cstart)
        `CHK("data end", e, dend)
    endtask

    // Bus fault pulse; only the first fault is kept
    task automatic bus_err(logic [31:0] a);
        @(negedge clk);
        berr = 1'b1;
        eaddr = a;
        if (m_err == 32'h0) m_err = a;
        @(negedge clk);
        berr = 1'b0;
        eaddr = ~a;
    endtask

    // Back-to-back watchdog events
    task automatic wdt_ev(int n);
        repeat (n) begin
            @(negedge clk);
            wev = 1'b1;
            m_wdt++;
        end
        @(negedge clk);
        wev = 1'b0;
        `CHK("wdt count", m_wdt, wcnt)
    endtask

    // System reset with a new size strap
    task automatic sys_reset(logic [1:0] c);
        @(negedge clk);
        rst_n = 1'b0;
        strap = c;
        m_code = c;
        m_simp = SIMP_RST;
        m_err = 32'h0;
        m_io = IO_PWR_RST;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk_map;
        rd_all;
        `CHK("wdt kept", m_wdt, wcnt)
        `CHK("io reset", m_io, io_pwr)
    endtask

    // Main sequence
    initial begin
        void'($urandom(40));
        base = $urandom() & 32'hFFFF_F000;
        scan = $urandom();
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        wrst_n = 1'b1;
        srst_n = 1'b1;
        repeat (2) @(negedge clk);
        rd_all;
        chk_map;
        // Strap moves after capture; the size code must not
        strap = 2'($urandom());
        // Random writes to the control table, bank power, size code and one unmapped place
        foreach (SIMP_OFS[i]) wr(SIMP_OFS[i], $urandom());
        wr(OFS_IO_PWR, $urandom());
        wr(OFS_SRAM_CFG, $urandom());
        wr('h100, $urandom());
        rd_all;
        // Asleep until after the watchdog checks: accesses must still complete
        slp = 1'b1;
        repeat (2) @(negedge clk);
        `CHK("sleep ack", 1'b1, sack)
        bus_err($urandom() | 32'h1);
        rd_chk(OFS_ERR_ADDR);
        bus_err($urandom() | 32'h1);
        rd_chk(OFS_ERR_ADDR);
        wr(OFS_ERR_ADDR, $urandom());
        rd_chk(OFS_ERR_ADDR);
        // Fault and clearing write on the same edge
        d = $urandom() | 32'h1;
        fork
            cpu.acc(1'b1, base + OFS_ERR_ADDR, $urandom(), rv, ak);
            bus_err(d);
        join
        rd_chk(OFS_ERR_ADDR);
        wr(OFS_WDT_CNT, 32'hFFFF_FFFE);
        wdt_ev(3);
        rd_chk(OFS_WDT_CNT);
        slp = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("sleep ack", 1'b0, sack)
        sys_reset(SRAM_320);
        sys_reset(SRAM_256);
        sys_reset(2'h0);
        // Watchdog-count reset touches only the count
        foreach (SIMP_OFS[i]) wr(SIMP_OFS[i], $urandom());
        @(negedge clk);
        wrst_n = 1'b0;
        m_wdt = WDT_CNT_RST;
        @(negedge clk);
        wrst_n = 1'b1;
        rd_all;
        wr(OFS_IO_PWR, $urandom() | 32'h1);
        // Standby reset clears the bank power register only
        @(negedge clk);
        srst_n = 1'b0;
        m_io = IO_PWR_RST;
        @(negedge clk);
        srst_n = 1'b1;
        rd_all;
        final_report;
    end
endmodule
